// ### hdl/pse_regs_pkg.sv
// Package for the detection, power-on fault and channel map registers.
// Assumes a byte-wide command interface already decoded from the host link.
package pse_regs_pkg;
	localparam logic [7:0] CMD_CAP_DETECT = 8'h22;
	localparam logic [7:0] CMD_FAULT_READ = 8'h24;
	localparam logic [7:0] CMD_FAULT_CLEAR = 8'h25;
	localparam logic [7:0] CMD_CHANNEL_MAP = 8'h26;
	localparam logic [7:0] CAP_DETECT_RESET = 8'h00;
	localparam logic [7:0] CAP_DETECT_MASK = 8'h55;
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam logic [7:0] CHANNEL_MAP_RESET = 8'hE4;
	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] FAULT_INVALID_DET = 2'h1;
	localparam logic [1:0] FAULT_CLASS_ERR = 2'h2;
	localparam logic [1:0] FAULT_NO_POWER = 2'h3;
	localparam int CHANNELS = 4;

	// One register access from the host command decoder.
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] command;
		logic [7:0] data;
	} reg_access_s;

	// Per-channel status from the power management core.
	typedef struct packed {
		logic [3:0] diag_mode;
		logic [3:0] off_mode;
		logic [3:0] res_valid;
		logic [3:0] power_enable_status;
		logic [3:0] turned_off;
		logic [3:0] start_fault;
		logic [7:0] fault_cause;
		logic [3:0] alloc_denied;
		logic [1:0] four_pair;
		logic [1:0] single_sig;
		logic [3:0] cap_done;
	} chan_status_s;
endpackage

// ### hdl/fault_code_store.sv
// Small register store for the four two-bit power-on fault codes.
// Assumes the caller resolves set and clear requests into per-channel strobes.
`timescale 1ns/1ps
`default_nettype none
module fault_code_store
	import pse_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] load,
	input wire logic [7:0] load_code,
	input wire logic [3:0] clear,
	output logic [7:0] codes
);
	// Loading beats clearing so a fault caught during a clearing read stays.
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_ch
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					codes[2*i+:2] <= FAULT_RESET[2*i+:2];
				end else if (load[i]) begin
					codes[2*i+:2] <= load_code[2*i+:2];
				end else if (clear[i]) begin
					codes[2*i+:2] <= FAULT_NONE;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### hdl/pse_detect_fault_remap_regs.sv
// Command registers for capacitance detection, power-on faults and remap.
// Assumes the host command decoder issues one-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module pse_detect_fault_remap_regs
	import pse_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire reg_access_s access,
	input wire chan_status_s status,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic [3:0] cap_measure_enable,
	output logic [3:0] detection_complete_event,
	output logic [7:0] channel_map
);
	// Register state and the stored fault codes.
	logic [7:0] cap_detect_enable_n;
	logic [7:0] power_on_fault_codes;

	// True when the given strobe carries the given command code.
	function automatic logic cmd_hit(input logic strobe,
		input logic [7:0] command, input logic [7:0] code);
		cmd_hit = strobe && command == code;
	endfunction

	// A channel records a fault on an unpowered start fault or a denial.
	function automatic logic fault_event(input logic start_fault,
		input logic powered, input logic denied);
		fault_event = (start_fault && !powered) || denied;
	endfunction

	// Fault code offered by one channel; a denial overrides the cause.
	function automatic logic [1:0] offered_code(input logic denied,
		input logic [1:0] cause);
		if (denied) begin
			offered_code = FAULT_NO_POWER;
		end else begin
			offered_code = cause;
		end
	endfunction

	// Code shared by a single-signature pair; the higher channel of the pair wins a tie.
	function automatic logic [1:0] pair_code(input logic [1:0] pair_load,
		input logic [3:0] pair_codes);
		if (pair_load[1]) begin
			pair_code = pair_codes[3:2];
		end else begin
			pair_code = pair_codes[1:0];
		end
	endfunction

	// Measurement is allowed only in diagnostic mode with no valid result.
	function automatic logic cap_allowed(input logic enabled,
		input logic diag, input logic res_ok);
		if (!diag) begin
			cap_allowed = 1'b0;
		end else if (res_ok) begin
			cap_allowed = 1'b0;
		end else begin
			cap_allowed = enabled;
		end
	endfunction

	// Read selection; the write-only enables and unknown codes read zero.
	function automatic logic [7:0] read_select(input logic [7:0] code,
		input logic [7:0] faults, input logic [7:0] map);
		case (code)
			CMD_FAULT_READ: begin
				read_select = faults;
			end
			CMD_FAULT_CLEAR: begin
				read_select = faults;
			end
			CMD_CHANNEL_MAP: begin
				read_select = map;
			end
			CMD_CAP_DETECT: begin
				read_select = 8'h00;
			end
			default: begin
				read_select = 8'h00;
			end
		endcase
	endfunction

	// Command decode; each strobe meets the same code compare.
	wire [7:0] cmd = access.command;
	wire wr_cap = cmd_hit(access.write, cmd, CMD_CAP_DETECT);
	wire wr_map = cmd_hit(access.write, cmd, CMD_CHANNEL_MAP);
	wire rd_clear = cmd_hit(access.read, cmd, CMD_FAULT_CLEAR);

	// A map write lands only while the whole channel group is off.
	wire group_off = &status.off_mode;
	wire map_accept = wr_map && group_off;

	// Fault capture per channel; a single-signature pair shares one code.
	logic [3:0] raw_load;
	logic [7:0] raw_code;
	logic [3:0] load;
	logic [7:0] load_code;
	genvar i;
	generate
		// Each channel offers a fault event and its code.
		for (i = 0; i < CHANNELS; i++) begin : g_fault
			assign raw_load[i] = fault_event(status.start_fault[i],
				status.power_enable_status[i],
				status.alloc_denied[i]);
			assign raw_code[2*i+:2] = offered_code(
				status.alloc_denied[i],
				status.fault_cause[2*i+:2]);
		end
		// Channels one and two, and three and four, form four-pair ports.
		for (i = 0; i < 2; i++) begin : g_pair
			wire joint = status.four_pair[i] && status.single_sig[i];
			wire any = raw_load[2*i] | raw_load[2*i+1];
			wire [1:0] jcode = pair_code(raw_load[2*i+:2],
				raw_code[4*i+:4]);
			assign load[2*i+:2] = joint ? {any, any} :
				raw_load[2*i+:2];
			assign load_code[4*i+:4] = joint ? {jcode, jcode} :
				raw_code[4*i+:4];
		end
	endgenerate

	// Clears come from turn-off and from the clearing read.
	wire [3:0] off_clear = status.turned_off;
	wire [3:0] read_clear = {4{rd_clear}};
	wire [3:0] clear = off_clear | read_clear;

	fault_code_store u_store (
		.clk(clk),
		.rst_n(rst_n),
		.load(load),
		.load_code(load_code),
		.clear(clear),
		.codes(power_on_fault_codes)
	);

	// Read data for the strobe of this cycle.
	wire [7:0] next_read_data = access.read ?
		read_select(cmd, power_on_fault_codes, channel_map) : 8'h00;

	// Even register bits carry the per-channel enables.
	logic [3:0] cap_enable_bits;
	logic [3:0] next_cap_enable;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_cap
			assign cap_enable_bits[i] = cap_detect_enable_n[2*i];
			assign next_cap_enable[i] = cap_allowed(cap_enable_bits[i],
				status.diag_mode[i], status.res_valid[i]);
		end
	endgenerate

	// Capacitance enable register; reserved odd bits stay zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_detect_enable_n <= CAP_DETECT_RESET;
		end else if (wr_cap) begin
			cap_detect_enable_n <= access.data & CAP_DETECT_MASK;
		end
	end

	// Channel map register; a write while any channel is on is dropped.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			channel_map <= CHANNEL_MAP_RESET;
		end else if (map_accept) begin
			channel_map <= access.data;
		end
	end

	// Read data, one cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_data <= 8'h00;
		end else begin
			read_data <= next_read_data;
		end
	end

	// Read answer flag, one cycle after any read strobe.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_valid <= 1'b0;
		end else begin
			read_valid <= access.read;
		end
	end

	// Measurement enable towards the detection engine.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_measure_enable <= 4'h0;
		end else begin
			cap_measure_enable <= next_cap_enable;
		end
	end

	// Completion event, a one-cycle copy of the engine's done pulse.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			detection_complete_event <= 4'h0;
		end else begin
			detection_complete_event <= status.cap_done;
		end
	end
endmodule
`default_nettype wire

// ### tb/pse_regs_chk.sv
// Port checker for the detect, fault and map register block.
// Bound onto the block from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module pse_regs_chk
	import pse_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire reg_access_s access,
	input wire chan_status_s status,
	input wire logic [7:0] read_data,
	input wire logic read_valid,
	input wire logic [3:0] cap_measure_enable,
	input wire logic [3:0] detection_complete_event,
	input wire logic [7:0] channel_map
);
	// Decoded requests, and a flag for cycles with no fault load.
	wire logic rd = access.read;
	wire logic mw = access.write && access.command == CMD_CHANNEL_MAP;
	wire logic quiet = !(|{status.start_fault, status.alloc_denied});
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_read_answer: assert property (rd |=> read_valid)
		else $error("read not answered");
	chk_cap_read: assert property (rd && access.command == 8'h22
		|=> read_data == 8'h00) else $error("cap enables read back");
	chk_map_read: assert property (rd && access.command == 8'h26
		|=> read_data == $past(channel_map)) else $error("map read bad");
	chk_map_write: assert property (mw && &status.off_mode
		|=> channel_map == $past(access.data)) else $error("map not set");
	chk_map_locked: assert property (mw && !(&status.off_mode)
		|=> $stable(channel_map)) else $error("map changed");
	chk_done_event: assert property (|status.cap_done
		|=> detection_complete_event == $past(status.cap_done))
		else $error("done event bad");
	chk_cap_gate: assert property ((cap_measure_enable &
		($past(status.res_valid) | ~$past(status.diag_mode))) == 4'h0)
		else $error("cap enable ungated");
	chk_clear_read: assert property (rd && access.command == 8'h25
		&& quiet ##1 quiet ##1 rd && access.command == 8'h24 && quiet
		|=> read_data == 8'h00) else $error("codes not cleared");
	cover property (mw);
	cover property (|status.cap_done);
	cover property (rd && access.command == 8'h25);
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Host model issuing one register command at a time.
// Assumes an answer just after the taken edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
	import pse_regs_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] read_data,
	output var reg_access_s access
);
	initial access = '0;
	// Holds a strobe for one edge, then scrambles the released fields.
	task automatic req(input logic w, input logic [7:0] c, d);
		@(posedge clk) access <= '{w, !w, c, d};
		@(posedge clk) access <= '{1'b0, 1'b0, ~c, ~d};
	endtask
	task automatic wr(input logic [7:0] c, d);
		req(1'b1, c, d);
	endtask
	task automatic rd(input logic [7:0] c, output logic [7:0] d);
		req(1'b0, c, 8'h00);
		#1 d = read_data;
	endtask
endmodule
`default_nettype wire

// ### tb/pse_detect_fault_remap_regs_test.sv
// Bench for the register block; status is driven directly.
// Register commands go through the host model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	fail_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module pse_detect_fault_remap_regs_test
	import pse_regs_pkg::*;
;
	logic clk = 0, rst_n = 0, rv;
	reg_access_s acc;
	chan_status_s st = '0;
	logic [7:0] rdat, d, map;
	logic [3:0] cme, dce;
	int fail_count = 0, samples_checked = 0, cycles = 0;
	host_model i_host (.clk(clk), .read_data(rdat), .access(acc));
	pse_detect_fault_remap_regs i_dut (.clk(clk), .rst_n(rst_n),
		.access(acc), .status(st), .read_data(rdat), .read_valid(rv),
		.cap_measure_enable(cme), .detection_complete_event(dce),
		.channel_map(map));
	task give_verdict;
		if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task rdchk(input logic [7:0] c, e);
		i_host.rd(c, d);
		`CHK({rv, d}, {1'b1, e})
	endtask
	// Pulses start fault, allocation denial and turn-off together.
	task kick(input logic [3:0] sf, ad, to);
		@(posedge clk) {st.start_fault, st.alloc_denied, st.turned_off} <= {sf, ad, to};
		@(posedge clk) {st.start_fault, st.alloc_denied, st.turned_off} <= '0;
	endtask
	// Clock, and a cycle ceiling that cuts a hang short.
	initial forever #4 clk = ~clk;
	always @(posedge clk) if (++cycles == 2000) begin
		fail_count++;
		give_verdict();
	end
	// Main sequence of register commands and status events.
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		rdchk(CMD_CHANNEL_MAP, 8'hE4);
		rdchk(CMD_FAULT_READ, 8'h00);
		rdchk(CMD_CAP_DETECT, 8'h00);
		@(posedge clk) {st.diag_mode, st.res_valid, st.fault_cause} <= 16'h72ED;
		i_host.wr(CMD_CAP_DETECT, 8'hFF);
		repeat (2) @(posedge clk);
		#1 `CHK(cme, 4'h5)
		i_host.wr(CMD_CAP_DETECT, 8'hAA);
		repeat (2) @(posedge clk);
		#1 `CHK(cme, 4'h0)
		@(posedge clk) st.cap_done <= 4'h9;
		@(posedge clk) st.cap_done <= 4'h0;
		#1 `CHK(dce, 4'h9)
		kick(4'h5, 4'h0, 4'h0);
		rdchk(CMD_FAULT_READ, 8'h21);
		rdchk(CMD_FAULT_CLEAR, 8'h21);
		rdchk(CMD_FAULT_READ, 8'h00);
		kick(4'h0, 4'h8, 4'h0);
		rdchk(CMD_FAULT_READ, 8'hC0);
		kick(4'h0, 4'h0, 4'h8);
		rdchk(CMD_FAULT_READ, 8'h00);
		@(posedge clk) st.power_enable_status <= 4'h1;
		kick(4'h1, 4'h0, 4'h0);
		rdchk(CMD_FAULT_READ, 8'h00);
		@(posedge clk) st.power_enable_status <= 4'h0;
		@(posedge clk) {st.four_pair, st.single_sig} <= 4'h5;
		kick(4'h1, 4'h0, 4'h0);
		rdchk(CMD_FAULT_CLEAR, 8'h05);
		i_host.wr(CMD_CAP_DETECT, 8'h01);
		repeat (2) @(posedge clk);
		#1 `CHK(cme, 4'h1)
		i_host.wr(CMD_CHANNEL_MAP, 8'h1B);
		rdchk(CMD_CHANNEL_MAP, 8'hE4);
		`CHK(map, 8'hE4)
		@(posedge clk) st.off_mode <= 4'hF;
		i_host.wr(CMD_CHANNEL_MAP, 8'h1B);
		rdchk(CMD_CHANNEL_MAP, 8'h1B);
		`CHK(map, 8'h1B)
		give_verdict();
	end
endmodule
bind pse_detect_fault_remap_regs pse_regs_chk i_chk (.clk(clk),
	.rst_n(rst_n), .access(access), .status(status),
	.read_data(read_data), .read_valid(read_valid),
	.cap_measure_enable(cap_measure_enable),
	.detection_complete_event(detection_complete_event),
	.channel_map(channel_map));
`default_nettype wire
